//--- design/ppfs_pkg.sv
// package: register map, reset values and carrier types of the port pin function select block
package ppfs_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] PPFS_OFS_P2_DATA  = 8'h00;
  localparam logic [7:0] PPFS_OFS_P2_DIR   = 8'h01;
  localparam logic [7:0] PPFS_OFS_P4_DATA  = 8'h02;
  localparam logic [7:0] PPFS_OFS_P4_DIR   = 8'h03;
  localparam logic [7:0] PPFS_OFS_P11_DATA = 8'h04;
  localparam logic [7:0] PPFS_OFS_P11_DIR  = 8'h05;
  localparam logic [7:0] PPFS_OFS_FUNC     = 8'h06;
  localparam logic [7:0] PPFS_OFS_INSW     = 8'h07;
  localparam logic [7:0] PPFS_OFS_OSC      = 8'h08;
  localparam logic [7:0] PPFS_OFS_LCD      = 8'h09;
  localparam logic [7:0] PPFS_OFS_ANA      = 8'h0A;
  localparam logic [7:0] PPFS_OFS_P12_PIN  = 8'h0B;
  localparam int         PPFS_NPORT        = 3;
  localparam int         PPFS_IDX_P2       = 0;
  localparam int         PPFS_IDX_P4       = 1;
  localparam int         PPFS_IDX_P11      = 2;
  // ==========================================================================
  // field positions
  localparam int PPFS_FN_SEG_ALL    = 0;
  localparam int PPFS_FN_SER_OUT    = 1;
  localparam int PPFS_FN_TX_OUT     = 2;
  localparam int PPFS_FN_ANA        = 3;
  localparam int PPFS_IS_IRQ0       = 0;
  localparam int PPFS_IS_CAPT       = 1;
  localparam int PPFS_IS_GATE       = 2;
  localparam int PPFS_IS_REROUTE    = 3;
  localparam int PPFS_IS_ALT_A      = 4;
  localparam int PPFS_IS_ALT_B      = 5;
  localparam int PPFS_OSC_SUB_SEL   = 4;
  localparam int PPFS_OSC_MAIN_SEL  = 6;
  localparam int PPFS_OSC_EXT_CLK   = 7;
  localparam int PPFS_ANA_DS_EN     = 7;
  localparam logic [1:0] PPFS_BIAS_QUARTER = 2'h2;
  localparam int PPFS_BIT_TX        = 2;
  localparam int PPFS_BIT_RX        = 3;
  // ==========================================================================
  // reset values
  localparam logic [7:0] PPFS_RST_LATCH = 8'h00;
  localparam logic [7:0] PPFS_RST_DIR   = 8'hFF;
  localparam logic [7:0] PPFS_RST_FUNC  = 8'h00;
  localparam logic [7:0] PPFS_RST_INSW  = 8'h00;
  localparam logic [7:0] PPFS_RST_OSC   = 8'h00;
  localparam logic [7:0] PPFS_RST_LCD   = 8'h00;
  localparam logic [7:0] PPFS_RST_ANA   = 8'h00;
  localparam logic [7:0] PPFS_INSW_MASK = 8'h3F;
  localparam logic [7:0] PPFS_OSC_MASK  = 8'hD0;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } ppfs_pad_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bit_op;
  } ppfs_bus_t;

  typedef struct packed {
    logic uart_rx_line;
    logic timer0_capture_in;
    logic ext_irq_in0;
    logic third_counter_en;
  } ppfs_route_t;
endpackage

//--- design/ppfs_top.sv
// module: port registers, pin multiplexing and input switch routing
// ============================================================================
// What this block does
// - input bit: writes go to the latch only, reads return the pin level
// - output bit: reads return the output latch, not the pin
// - bit set/clear reads all 8 bits, changes one, writes all 8 back
// - segment select 1 makes shared pins LCD segments unless reroute is set; 0 gives port use
// - capture switch 1 feeds serial receive into timer 0 capture input
// - interrupt switch 1 feeds serial receive into external interrupt 0
// - gating switch 1 lets the second timer gate the third counter's input
// - quarter bias turns port 4 bit 0 into the LCD bias input
// - oscillator pin mode resets to 00H; all four pins then are input ports
// - rerouted serial functions reach their pins only via input switch bits
// - during on-chip debug the main oscillator pins act as debug mode pins
// - port 2 pins decided by function, config, direction, converter
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module ppfs_top
  import ppfs_pkg::*;
#(
  parameter int PORT_W = 8
)(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire ppfs_pkg::ppfs_bus_t bus,
  output logic [7:0]              rdata,
  input  wire logic [7:0]         p2_pin_in,
  input  wire logic [7:0]         p4_pin_in,
  input  wire logic [7:0]         p11_pin_in,
  input  wire logic [3:0]         p12_pin_in,
  output ppfs_pkg::ppfs_pad_t     p2_pad,
  output ppfs_pkg::ppfs_pad_t     p4_pad,
  output ppfs_pkg::ppfs_pad_t     p11_pad,
  input  wire logic [7:0]         seg_drive_p2,
  input  wire logic [7:0]         seg_drive_p11,
  input  wire logic               uart_tx_line,
  input  wire logic               rx_p15_pin,
  input  wire logic               capt_pin,
  input  wire logic               irq0_pin,
  input  wire logic               gate_timer_out,
  input  wire logic               debug_en,
  input  wire logic [1:0]         lcd_bias_sel_in,
  output ppfs_pkg::ppfs_route_t   route,
  output logic                    tx_on_p13,
  output logic                    tx_on_p16,
  output logic [7:0]              key_return_in,
  output logic                    lcd_bias_v3_en,
  output logic [7:0]              analog_pin_en,
  output logic [2:0]              analog_channel_sel,
  output logic                    delta_sigma_mode,
  output logic                    x1_osc_mode,
  output logic                    ext_clk_mode,
  output logic                    xt_osc_mode,
  output logic                    debug_pin_a,
  output logic                    debug_pin_b
);
  import ppfs_pkg::*;

  generate
    if (PORT_W != 8)
    begin : g_chk
      $error("ppfs_top serves 8-bit ports only");
    end
  endgenerate

  // ==========================================================================
  // storage
  logic [7:0] latch_q [PPFS_NPORT];
  logic [7:0] dir_q   [PPFS_NPORT];
  logic [7:0] func_q, insw_q, osc_q, lcd_q, ana_q, rdata_q;
  logic [7:0] pin_in  [PPFS_NPORT];
  logic [7:0] dig_en  [PPFS_NPORT];
  logic [7:0] port_rd [PPFS_NPORT];
  logic [7:0] rmw_val [PPFS_NPORT];
  logic [7:0] dat_wr  [PPFS_NPORT];

  // pin level for input bits, latch for output bits
  function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin, input logic [7:0] en);
    port_view = (dir & pin & en) | (~dir & latch);
  endfunction

  function automatic logic [7:0] bit_apply(input logic [7:0] base, input logic [7:0] wd);
    logic [7:0] mask;
    mask      = 8'h01 << wd[2:0];
    bit_apply = wd[3] ? (base | mask) : (base & ~mask);
  endfunction

  // ==========================================================================
  // decode
  wire quarter_bias = (lcd_bias_sel_in == PPFS_BIAS_QUARTER);
  wire seg_all      = func_q[PPFS_FN_SEG_ALL];
  wire ana_seg      = func_q[PPFS_FN_ANA];
  wire reroute      = insw_q[PPFS_IS_REROUTE];
  wire alt_a        = insw_q[PPFS_IS_ALT_A];
  wire alt_b        = insw_q[PPFS_IS_ALT_B];
  wire tx_seg_route = reroute & ~alt_a & ~alt_b;
  wire rx_p15_route = alt_a & ~alt_b;
  wire osc_port     = (osc_q == PPFS_RST_OSC);
  wire [7:0] ana_cfg_mask = (8'hFF >> (4'h8 - {1'b0, ana_q[2:0]})) & {8{ana_q[2:0] != 3'h0}};
  wire [7:0] ana_pins     = ana_seg ? 8'h00 : ((ana_cfg_mask | {8{ana_q[PPFS_ANA_DS_EN]}})
                                               & dir_q[PPFS_IDX_P2]);

  assign pin_in[PPFS_IDX_P2]  = p2_pin_in;
  assign pin_in[PPFS_IDX_P4]  = p4_pin_in;
  assign pin_in[PPFS_IDX_P11] = p11_pin_in;
  assign dig_en[PPFS_IDX_P2]  = ana_seg ? 8'h00 : ~ana_pins;
  assign dig_en[PPFS_IDX_P4]  = {7'h7F, ~quarter_bias};
  assign dig_en[PPFS_IDX_P11] = (seg_all & ~reroute) ? 8'hF0 : 8'hFF;

  genvar gi;
  generate
    for (gi = 0; gi < PPFS_NPORT; gi++)
    begin : g_port
      assign port_rd[gi] = port_view(latch_q[gi], dir_q[gi], pin_in[gi], dig_en[gi]);
      assign rmw_val[gi] = bit_apply(port_rd[gi], bus.wdata);
      assign dat_wr[gi]  = bus.bit_op ? rmw_val[gi] : bus.wdata;
      wire sel_dat = (bus.addr == 8'(2 * gi));
      wire sel_dir = (bus.addr == 8'(2 * gi + 1));
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          latch_q[gi] <= PPFS_RST_LATCH;
          dir_q[gi]   <= PPFS_RST_DIR;
        end
        else
        begin
          if ((bus.wr | bus.bit_op) & sel_dat)
            latch_q[gi] <= dat_wr[gi];
          if (bus.wr & sel_dir)
            dir_q[gi] <= bus.wdata;
          else if (bus.bit_op & sel_dir)
            dir_q[gi] <= bit_apply(dir_q[gi], bus.wdata);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // control registers
  wire wr_func = (bus.wr | bus.bit_op) & (bus.addr == PPFS_OFS_FUNC);
  wire wr_insw = (bus.wr | bus.bit_op) & (bus.addr == PPFS_OFS_INSW);
  wire wr_osc  = (bus.wr | bus.bit_op) & (bus.addr == PPFS_OFS_OSC);
  wire wr_lcd  = (bus.wr | bus.bit_op) & (bus.addr == PPFS_OFS_LCD);
  wire wr_ana  = (bus.wr | bus.bit_op) & (bus.addr == PPFS_OFS_ANA);
  wire [7:0] ctl_src_func = bus.bit_op ? bit_apply(func_q, bus.wdata) : bus.wdata;
  wire [7:0] ctl_src_insw = bus.bit_op ? bit_apply(insw_q, bus.wdata) : bus.wdata;
  wire [7:0] ctl_src_osc  = bus.bit_op ? bit_apply(osc_q, bus.wdata) : bus.wdata;
  wire [7:0] ctl_src_lcd  = bus.bit_op ? bit_apply(lcd_q, bus.wdata) : bus.wdata;
  wire [7:0] ctl_src_ana  = bus.bit_op ? bit_apply(ana_q, bus.wdata) : bus.wdata;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      func_q <= PPFS_RST_FUNC;
      insw_q <= PPFS_RST_INSW;
      osc_q  <= PPFS_RST_OSC;
      lcd_q  <= PPFS_RST_LCD;
      ana_q  <= PPFS_RST_ANA;
    end
    else
    begin
      if (wr_func)
        func_q <= {4'h0, ctl_src_func[3:0]};
      if (wr_insw)
        insw_q <= ctl_src_insw & PPFS_INSW_MASK;
      if (wr_osc)
        osc_q <= ctl_src_osc & PPFS_OSC_MASK;
      if (wr_lcd)
        lcd_q <= {4'h0, ctl_src_lcd[3:0]};
      if (wr_ana)
        ana_q <= ctl_src_ana;
    end
  end

  // ==========================================================================
  // read port: data stand in the cycle after the strobe only
  wire [7:0] p12_view = osc_port ? {4'h0, p12_pin_in} : 8'h00;
  logic [7:0] rd_mux;
  always_comb
  begin
    case (bus.addr)
      PPFS_OFS_P2_DATA:  rd_mux = port_rd[PPFS_IDX_P2];
      PPFS_OFS_P2_DIR:   rd_mux = dir_q[PPFS_IDX_P2];
      PPFS_OFS_P4_DATA:  rd_mux = port_rd[PPFS_IDX_P4];
      PPFS_OFS_P4_DIR:   rd_mux = dir_q[PPFS_IDX_P4];
      PPFS_OFS_P11_DATA: rd_mux = port_rd[PPFS_IDX_P11];
      PPFS_OFS_P11_DIR:  rd_mux = dir_q[PPFS_IDX_P11];
      PPFS_OFS_FUNC:     rd_mux = func_q;
      PPFS_OFS_INSW:     rd_mux = insw_q;
      PPFS_OFS_OSC:      rd_mux = osc_q;
      PPFS_OFS_LCD:      rd_mux = {lcd_q[7:2], lcd_bias_sel_in};
      PPFS_OFS_ANA:      rd_mux = ana_q;
      PPFS_OFS_P12_PIN:  rd_mux = p12_view;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else
      rdata_q <= bus.rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_q;

  // ==========================================================================
  // pad drive; oe_n low means the pin is driven
  // segment mode ignores direction and latch, so they may be left as they are
  wire [7:0] p2_seg_oe = {8{ana_seg}};
  wire [7:0] p11_seg   = (seg_all & ~reroute) ? 8'h0F : 8'h00;
  wire [7:0] p11_tx    = tx_seg_route ? 8'h04 : 8'h00;
  wire [7:0] p2_drv_d  = ana_seg ? seg_drive_p2 : latch_q[PPFS_IDX_P2];
  wire [7:0] p2_oe_d   = ~(p2_seg_oe | (~dir_q[PPFS_IDX_P2] & ~ana_pins));
  wire [7:0] p4_oe_d   = ~(~dir_q[PPFS_IDX_P4] & dig_en[PPFS_IDX_P4]);
  wire [7:0] p11_drv_d = (p11_seg & seg_drive_p11)
                       | (~p11_seg & latch_q[PPFS_IDX_P11] & ~(p11_tx & {8{~uart_tx_line}}));
  wire [7:0] p11_oe_d  = ~(p11_seg | (~dir_q[PPFS_IDX_P11] & ~p11_seg));

  // ==========================================================================
  // peripheral routing
  wire rx_src = tx_seg_route ? p11_pin_in[PPFS_BIT_RX] :
                rx_p15_route ? rx_p15_pin : 1'b1;
  wire capt_d = insw_q[PPFS_IS_CAPT] ? rx_src : capt_pin;
  wire irq_d  = insw_q[PPFS_IS_IRQ0] ? rx_src : irq0_pin;
  wire gate_d = insw_q[PPFS_IS_GATE] ? gate_timer_out : 1'b1;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      p2_pad        <= '{dout: 8'h00, oe_n: 8'hFF};
      p4_pad        <= '{dout: 8'h00, oe_n: 8'hFF};
      p11_pad       <= '{dout: 8'h00, oe_n: 8'hFF};
      route         <= '{uart_rx_line: 1'b1, timer0_capture_in: 1'b0, ext_irq_in0: 1'b0,
                         third_counter_en: 1'b1};
      key_return_in <= 8'h00;
    end
    else
    begin
      p2_pad        <= '{dout: p2_drv_d, oe_n: p2_oe_d};
      p4_pad        <= '{dout: latch_q[PPFS_IDX_P4], oe_n: p4_oe_d};
      p11_pad       <= '{dout: p11_drv_d, oe_n: p11_oe_d};
      route         <= '{uart_rx_line: rx_src, timer0_capture_in: capt_d, ext_irq_in0: irq_d,
                         third_counter_en: gate_d};
      key_return_in <= p4_pin_in & dir_q[PPFS_IDX_P4] & dig_en[PPFS_IDX_P4];
    end
  end

  // ==========================================================================
  // mode outputs
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_on_p13          <= 1'b0;
      tx_on_p16          <= 1'b0;
      lcd_bias_v3_en     <= 1'b0;
      analog_pin_en      <= 8'h00;
      analog_channel_sel <= 3'h0;
      delta_sigma_mode   <= 1'b0;
      x1_osc_mode        <= 1'b0;
      ext_clk_mode       <= 1'b0;
      xt_osc_mode        <= 1'b0;
      debug_pin_a        <= 1'b0;
      debug_pin_b        <= 1'b0;
    end
    else
    begin
      tx_on_p13          <= func_q[PPFS_FN_SER_OUT];
      tx_on_p16          <= func_q[PPFS_FN_TX_OUT] & rx_p15_route;
      lcd_bias_v3_en     <= quarter_bias;
      analog_pin_en      <= ana_pins;
      analog_channel_sel <= ana_q[6:4];
      delta_sigma_mode   <= ana_q[PPFS_ANA_DS_EN];
      x1_osc_mode        <= osc_q[PPFS_OSC_MAIN_SEL] & ~osc_q[PPFS_OSC_EXT_CLK] & ~debug_en;
      ext_clk_mode       <= osc_q[PPFS_OSC_MAIN_SEL] & osc_q[PPFS_OSC_EXT_CLK] & ~debug_en;
      xt_osc_mode        <= osc_q[PPFS_OSC_SUB_SEL];
      debug_pin_a        <= debug_en & p12_pin_in[1];
      debug_pin_b        <= debug_en & p12_pin_in[2];
    end
  end

  // ==========================================================================
  // checks
  a_input_reads_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus.rd && bus.addr == PPFS_OFS_P4_DATA && dir_q[PPFS_IDX_P4] == 8'hFF && !quarter_bias
    |=> rdata == $past(p4_pin_in))
    else $error("input port read did not return pin level");

  a_output_reads_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus.rd && bus.addr == PPFS_OFS_P4_DATA && dir_q[PPFS_IDX_P4] == 8'h00
    |=> rdata == $past(latch_q[PPFS_IDX_P4]))
    else $error("output port read did not return latch");

  a_bit_op_rmw: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus.bit_op && bus.addr == PPFS_OFS_P4_DATA
    |=> latch_q[PPFS_IDX_P4] == bit_apply($past(port_rd[PPFS_IDX_P4]), $past(bus.wdata)))
    else $error("bit manipulation did not write back whole port");

  a_seg_pins_driven: assert property (@(posedge ref_clk) disable iff (!resetn)
    seg_all && !reroute ##1 $stable(func_q) |-> p11_pad.oe_n[3:0] == 4'h0)
    else $error("segment pins not driven in segment mode");

  a_tx_reroute: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_seg_route && !dir_q[PPFS_IDX_P11][PPFS_BIT_TX] && latch_q[PPFS_IDX_P11][PPFS_BIT_TX]
    |=> p11_pad.dout[PPFS_BIT_TX] == $past(uart_tx_line))
    else $error("serial transmit not on rerouted pin");

  a_capture_source: assert property (@(posedge ref_clk) disable iff (!resetn)
    insw_q[PPFS_IS_CAPT] |=> route.timer0_capture_in == $past(rx_src))
    else $error("capture input not taken from serial receive");

  a_irq_source: assert property (@(posedge ref_clk) disable iff (!resetn)
    !insw_q[PPFS_IS_IRQ0] |=> route.ext_irq_in0 == $past(irq0_pin))
    else $error("interrupt input not from its own pin");

  a_counter_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    insw_q[PPFS_IS_GATE] |=> route.third_counter_en == $past(gate_timer_out))
    else $error("counter gate not following timer output");

  a_bias_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    quarter_bias [*2] |-> lcd_bias_v3_en && p4_pad.oe_n[0] && !key_return_in[0])
    else $error("bias pin still used as port");

  a_osc_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> osc_q == 8'h00 && !x1_osc_mode && !ext_clk_mode)
    else $error("oscillator mode not cleared at reset");

  a_debug_pins: assert property (@(posedge ref_clk) disable iff (!resetn)
    !debug_en |=> !debug_pin_a && !debug_pin_b)
    else $error("debug pins active without debug");

  a_debug_osc_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    debug_en |=> !x1_osc_mode && !ext_clk_mode)
    else $error("main oscillator mode active during debug");

  c_bit_op: cover property (@(posedge ref_clk) disable iff (!resetn)
    bus.bit_op && bus.addr == PPFS_OFS_P4_DATA && dir_q[PPFS_IDX_P4] != 8'h00);
  c_tx_route: cover property (@(posedge ref_clk) disable iff (!resetn) tx_seg_route && !seg_all);
  c_rx_capture: cover property (@(posedge ref_clk) disable iff (!resetn)
    insw_q[PPFS_IS_CAPT] && insw_q[PPFS_IS_IRQ0] && tx_seg_route);
  c_quarter: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(quarter_bias));

endmodule // ppfs_top

//--- sim/ppfs_pin_model.sv
// partner model: external pins resolved against the pads and an outside level
`timescale 1ns/1ps
module ppfs_pin_model (
  input  wire ppfs_pkg::ppfs_pad_t p2_pad,
  input  wire ppfs_pkg::ppfs_pad_t p4_pad,
  input  wire ppfs_pkg::ppfs_pad_t p11_pad,
  input  wire logic [7:0]          ext_level,
  output logic [7:0]               p2_pin_in,
  output logic [7:0]               p4_pin_in,
  output logic [7:0]               p11_pin_in
);
  import ppfs_pkg::*;
  // ==========================================================================
  // pin resolution
  // released pins follow the outside level, never the last pad value
  assign p2_pin_in  = (p2_pad.dout & ~p2_pad.oe_n) | (ext_level & p2_pad.oe_n);
  assign p4_pin_in  = (p4_pad.dout & ~p4_pad.oe_n) | (ext_level & p4_pad.oe_n);
  assign p11_pin_in = (p11_pad.dout & ~p11_pad.oe_n) | (ext_level & p11_pad.oe_n);
endmodule // ppfs_pin_model

//--- sim/ppfs_top_tb.sv
// testbench: port access, pin multiplexing and input switch routing
`timescale 1ns/1ps
module ppfs_top_tb;
  import ppfs_pkg::*;
  // ==========================================================================
  // signals
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  ppfs_bus_t   bus = '0;
  logic [7:0]  rdata, p2_pin_in, p4_pin_in, p11_pin_in, key_return_in, analog_pin_en;
  logic [7:0]  ext_level = 8'h5A;
  logic [3:0]  p12_pin_in = 4'h9;
  ppfs_pad_t   p2_pad, p4_pad, p11_pad;
  logic [7:0]  seg_drive_p2 = 8'h00;
  logic [7:0]  seg_drive_p11 = 8'h05;
  logic        uart_tx_line = 1'b1, rx_p15_pin = 1'b0, capt_pin = 1'b0, irq0_pin = 1'b0;
  logic        gate_timer_out = 1'b0, debug_en = 1'b0;
  logic [1:0]  lcd_bias_sel_in = 2'h0;
  ppfs_route_t route;
  logic        tx_on_p13, tx_on_p16, lcd_bias_v3_en, delta_sigma_mode, x1_osc_mode, ext_clk_mode;
  logic        xt_osc_mode, debug_pin_a, debug_pin_b;
  logic [2:0]  analog_channel_sel;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #5 ref_clk = ~ref_clk;

  ppfs_top ppfs_top_i (.ref_clk, .resetn, .bus, .rdata, .p2_pin_in, .p4_pin_in, .p11_pin_in, .p12_pin_in,
    .p2_pad, .p4_pad, .p11_pad, .seg_drive_p2, .seg_drive_p11, .uart_tx_line, .rx_p15_pin, .capt_pin,
    .irq0_pin, .gate_timer_out, .debug_en, .lcd_bias_sel_in, .route, .tx_on_p13, .tx_on_p16, .key_return_in,
    .lcd_bias_v3_en, .analog_pin_en, .analog_channel_sel, .delta_sigma_mode, .x1_osc_mode, .ext_clk_mode,
    .xt_osc_mode, .debug_pin_a, .debug_pin_b);

  ppfs_pin_model ppfs_pin_model_i (.p2_pad, .p4_pad, .p11_pad, .ext_level, .p2_pin_in, .p4_pin_in,
    .p11_pin_in);
  // ==========================================================================
  // access and compare tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= {a, d, 3'b100};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic bop(input logic [7:0] a, input logic [2:0] b, input logic v);
    @(posedge ref_clk);
    bus <= {a, 4'h0, v, b, 3'b001};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= {a, 8'h00, 3'b010};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    chk(what, exp, rdata);
  endtask
  // pads and routes are registered, pins sampled: allow a few edges
  task automatic st;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      final_report;
    end
  end
  // ==========================================================================
  // scenarios
  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    st;
    rd("p4 dir", PPFS_OFS_P4_DIR, 8'hFF);
    rd("osc", PPFS_OFS_OSC, 8'h00);
    rd("p12 pins", PPFS_OFS_P12_PIN, 8'h09);
    chk1("x1 mode", 1'b0, x1_osc_mode);
    rd("unmapped", 8'h20, 8'h00);
    done("reset");
    wr(PPFS_OFS_P4_DATA, 8'h3C);
    st;
    chk("p4 oe_n", 8'hFF, p4_pad.oe_n);
    rd("p4 input", PPFS_OFS_P4_DATA, 8'h5A);
    wr(PPFS_OFS_P4_DIR, 8'hF0);
    st;
    rd("p4 mixed", PPFS_OFS_P4_DATA, 8'h5C);
    chk("p4 dout", 8'h0C, {4'h0, p4_pad.dout[3:0]});
    wr(PPFS_OFS_P4_DIR, 8'h00);
    rd("p4 output", PPFS_OFS_P4_DATA, 8'h3C);
    done("direction");
    wr(PPFS_OFS_P4_DATA, 8'h00);
    wr(PPFS_OFS_P4_DIR, 8'hFE);
    @(posedge ref_clk) ext_level <= 8'hFF;
    st;
    bop(PPFS_OFS_P4_DATA, 3'd0, 1'b1);
    wr(PPFS_OFS_P4_DIR, 8'h00);
    rd("p4 after bit set", PPFS_OFS_P4_DATA, 8'hFF);
    wr(PPFS_OFS_P4_DATA, 8'h01);
    rd("p4 latch rewritten", PPFS_OFS_P4_DATA, 8'h01);
    done("bit op");
    wr(PPFS_OFS_FUNC, 8'h01);
    st;
    chk("p11 seg", 8'h05, {4'h0, p11_pad.dout[3:0]});
    chk("p11 seg oe_n", 8'hF0, p11_pad.oe_n);
    chk1("p13 plain port", 1'b0, tx_on_p13);
    wr(PPFS_OFS_INSW, 8'h08);
    wr(PPFS_OFS_P11_DIR, 8'hFB);
    wr(PPFS_OFS_P11_DATA, 8'h04);
    @(posedge ref_clk) uart_tx_line <= 1'b0;
    st;
    chk1("tx low", 1'b0, p11_pad.dout[2]);
    chk1("tx driven", 1'b0, p11_pad.oe_n[2]);
    @(posedge ref_clk) uart_tx_line <= 1'b1;
    st;
    chk1("tx high", 1'b1, p11_pad.dout[2]);
    done("segments and tx");
    wr(PPFS_OFS_INSW, 8'h0B);
    @(posedge ref_clk) ext_level <= 8'h08;
    st;
    chk1("rx", 1'b1, route.uart_rx_line);
    chk1("capture rx", 1'b1, route.timer0_capture_in);
    chk1("irq rx", 1'b1, route.ext_irq_in0);
    @(posedge ref_clk) ext_level <= 8'h00;
    st;
    chk1("capture rx low", 1'b0, route.timer0_capture_in);
    chk1("irq rx low", 1'b0, route.ext_irq_in0);
    wr(PPFS_OFS_INSW, 8'h00);
    @(posedge ref_clk) capt_pin <= 1'b1;
    st;
    chk1("capture pin", 1'b1, route.timer0_capture_in);
    chk1("irq pin", 1'b0, route.ext_irq_in0);
    wr(PPFS_OFS_INSW, 8'h04);
    st;
    chk1("gate low", 1'b0, route.third_counter_en);
    @(posedge ref_clk) gate_timer_out <= 1'b1;
    st;
    chk1("gate high", 1'b1, route.third_counter_en);
    rd("input switch", PPFS_OFS_INSW, 8'h04);
    wr(PPFS_OFS_FUNC, 8'h06);
    wr(PPFS_OFS_INSW, 8'h10);
    st;
    chk1("tx on p13", 1'b1, tx_on_p13);
    chk1("tx on p16", 1'b1, tx_on_p16);
    chk1("rx from p15", 1'b0, route.uart_rx_line);
    wr(PPFS_OFS_FUNC, 8'h00);
    st;
    chk1("p16 plain port", 1'b0, tx_on_p16);
    done("input switch");
    @(posedge ref_clk) lcd_bias_sel_in <= PPFS_BIAS_QUARTER;
    st;
    chk1("bias in", 1'b1, lcd_bias_v3_en);
    chk1("bias pin free", 1'b1, p4_pad.oe_n[0]);
    wr(PPFS_OFS_P4_DIR, 8'hFF);
    @(posedge ref_clk) ext_level <= 8'hFF;
    st;
    chk("key return bias", 8'hFE, key_return_in);
    @(posedge ref_clk) lcd_bias_sel_in <= 2'h1;
    st;
    chk1("bias off", 1'b0, lcd_bias_v3_en);
    chk("key return", 8'hFF, key_return_in);
    done("bias");
    wr(PPFS_OFS_OSC, 8'hFF);
    st;
    rd("osc mask", PPFS_OFS_OSC, 8'hD0);
    rd("p12 in osc mode", PPFS_OFS_P12_PIN, 8'h00);
    chk1("ext clk", 1'b1, ext_clk_mode);
    chk1("sub osc", 1'b1, xt_osc_mode);
    wr(PPFS_OFS_OSC, 8'h40);
    st;
    chk1("x1 osc", 1'b1, x1_osc_mode);
    chk1("ext clk off", 1'b0, ext_clk_mode);
    done("oscillator pins");
    @(posedge ref_clk) debug_en <= 1'b1;
    p12_pin_in <= 4'h6;
    st;
    chk("debug pins", 8'h03, {6'h00, debug_pin_b, debug_pin_a});
    chk1("x1 off in debug", 1'b0, x1_osc_mode);
    done("debug");
    wr(PPFS_OFS_ANA, 8'hA0);
    st;
    chk("channel", 8'h02, {5'h00, analog_channel_sel});
    chk1("delta sigma", 1'b1, delta_sigma_mode);
    chk("analog pins", 8'hFF, analog_pin_en);
    chk("p2 analog oe_n", 8'hFF, p2_pad.oe_n);
    rd("p2 analog read", PPFS_OFS_P2_DATA, 8'h00);
    wr(PPFS_OFS_FUNC, 8'h08);
    st;
    chk("p2 seg oe_n", 8'h00, p2_pad.oe_n);
    done("analog");
    final_report;
  end
endmodule // ppfs_top_tb
